// file: src/aoc_pkg.sv
// constants, field layouts and enumerations of the analog output channel configuration block
// Contract
// - after reset each channel is voltage output with the bipolar ten volt range
// - type selects voltage, current or off; three ranges per type
// - output rate sets sub-cycles per data cycle; default one, locked while running
// - supply diagnosis enable per channel, default off, locked while running
// - wire break diagnosis enable per channel, default off
// - short to ground only for voltage channels beyond plus or minus half volt
// - open circuit only for current channels beyond plus or minus three milliamps
// - overflow diagnosis enable per channel, raised above the overrange limit
// - underflow diagnosis enable per channel, raised below the underrange limit
// - on cpu stop each channel turns off, holds, or drives its substitute value
// - per channel substitute value, default zero, driven in stop with substitute reaction
// - staged parameters are validated only on commit of the complete set
// - every channel not of type off with supply diagnosis enabled reports the supply failure itself
package aoc_pkg;
  localparam int unsigned NCH = 8;
  localparam int unsigned CH_W = 13;
  localparam int unsigned NDIAG = 5;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets; channel blocks are eight words each
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STS0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MSK0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STS1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MSK1 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STAGE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_ACT = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_SUB = 8'h80;

  // control register bits
  localparam int unsigned CTRL_STOP = 0;
  localparam int unsigned CTRL_RUN = 1;
  localparam int unsigned CTRL_COMMIT = 2;
  localparam int unsigned CTRL_BUSY = 3;

  // channel word fields
  localparam int unsigned TYPE_LSB = 0;
  localparam int unsigned RANGE_LSB = 2;
  localparam int unsigned REACT_LSB = 4;
  localparam int unsigned EN_LSB = 8;

  // diagnostic indices, also enable bit = EN_LSB + index
  localparam int unsigned D_SUP = 0;
  localparam int unsigned D_WIRE = 1;
  localparam int unsigned D_SHORT = 2;
  localparam int unsigned D_OVER = 3;
  localparam int unsigned D_UNDER = 4;

  // status bit positions
  localparam int unsigned S0_SUP = 0;
  localparam int unsigned S0_WIRE = 8;
  localparam int unsigned S0_SHORT = 16;
  localparam int unsigned S0_OVER = 24;
  localparam int unsigned S1_UNDER = 0;
  localparam int unsigned S1_ERR = 8;

  typedef enum logic [1:0] {TYPE_VOLT = 2'b00, TYPE_CURR = 2'b01, TYPE_OFF = 2'b10} aoc_type_e;
  // range 0: 1..5 V / 0..20 mA, 1: 0..10 V / 4..20 mA, 2: bipolar
  typedef enum logic [1:0] {RANGE_A = 2'b00, RANGE_B = 2'b01, RANGE_BIP = 2'b10} aoc_range_e;
  typedef enum logic [1:0] {REACT_OFF = 2'b00, REACT_HOLD = 2'b01, REACT_SUBST = 2'b10} aoc_react_e;
  typedef enum logic [0:0] {CFG_IDLE = 1'b0, CFG_CHECK = 1'b1} aoc_cfg_e;

  // reset values
  localparam logic [CH_W-1:0] CFG_RST = 13'h0008;
  localparam logic [4:0] RATE_RST = 5'h01;
  localparam logic [4:0] RATE_MIN = 5'h01;
  localparam logic [4:0] RATE_MAX = 5'h10;
  localparam logic [15:0] SUB_RST = 16'h0000;
endpackage

// file: src/aoc_mem.sv
// substitute value store with registered read port
`timescale 1ns/100ps
`default_nettype none
module aoc_mem #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 8,
  parameter int unsigned AW = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  import aoc_pkg::*;

  typedef struct packed {
    logic [D-1:0][W-1:0] word;
    logic [W-1:0] rd;
  } aoc_mem_s;

  aoc_mem_s st_ff;
  aoc_mem_s nxt_st;

  // read every cycle; a write to the same word shows its old value once
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.word[wr_addr] = wr_data;
    end
    nxt_st.rd = st_ff.word[rd_addr];
  end

  // every word starts at the substitute default
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff.word <= {D{W'(SUB_RST)}};
      st_ff.rd <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd;
endmodule
`default_nettype wire

// file: src/aoc_top.sv
// per channel configuration, stop reaction and diagnostic gating of the eight channel output
`timescale 1ns/100ps
`default_nettype none
module aoc_top
  import aoc_pkg::*;
#(
  parameter int unsigned VAL_W = 16,
  // plain defaults; trim to the value encoding of the output stage
  parameter logic signed [15:0] SC_TH = 16'sh0200,
  parameter logic signed [15:0] OC_TH = 16'sh0400,
  parameter logic signed [15:0] OVR_LIM = 16'sh7000,
  parameter logic signed [15:0] UND_LIM = 16'sh9000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [aoc_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [aoc_pkg::NCH*VAL_W-1:0] cmd_value,
  input wire logic supply_ok,
  input wire logic [aoc_pkg::NCH-1:0] wire_det,
  input wire logic [aoc_pkg::NCH-1:0] short_det,
  output logic [aoc_pkg::NCH*VAL_W-1:0] drive_value,
  output logic [aoc_pkg::NCH-1:0] drive_en,
  output wire logic [2*aoc_pkg::NCH-1:0] out_type,
  output wire logic [2*aoc_pkg::NCH-1:0] out_range,
  output logic [4:0] output_rate,
  output logic irq
);
  import aoc_pkg::*;

  // declared first so the channel loop assertions below pick up the same clock and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  localparam logic signed [15:0] NEG_SC = -SC_TH;
  localparam logic signed [15:0] NEG_OC = -OC_TH;

  typedef struct packed {
    logic [31:0] rdata;
    logic rd_sub;
    logic cpu_stop;
    logic run;
    logic [4:0] rate;
    logic [NCH-1:0][CH_W-1:0] stage;
    logic [NCH-1:0][CH_W-1:0] act;
    logic [31:0] sts0;
    logic [31:0] msk0;
    logic [8:0] sts1;
    logic [8:0] msk1;
    logic [NCH-1:0][VAL_W-1:0] drive;
    logic [NCH-1:0] drive_en;
    logic [2:0] scan;
    logic [2:0] scan_d;
    logic scan_v;
    logic [NCH-1:0][NDIAG-1:0] cond_q;
    aoc_cfg_e cfg;
  } aoc_state_s;

  aoc_state_s st_ff;
  aoc_state_s nxt_st;
  wire [NCH-1:0][NDIAG-1:0] cond;
  logic [NCH-1:0][NDIAG-1:0] evt;
  logic [VAL_W-1:0] mem_rd;
  logic [2:0] mem_ra;
  logic mem_we;
  logic all_ok;
  logic err_evt;
  logic [31:0] set0;
  logic [31:0] clr0;
  logic [8:0] set1;
  logic [8:0] clr1;
  logic [2:0] k;

  // same 32-byte block as base
  function automatic logic in_blk(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    in_blk = (a[ADDR_W-1:5] == base[ADDR_W-1:5]);
  endfunction

  function automatic logic [2:0] ch_of(input logic [ADDR_W-1:0] a);
    ch_of = a[4:2];
  endfunction

  // the fourth code of each two-bit field is illegal
  function automatic logic word_ok(input logic [CH_W-1:0] w);
    word_ok = (w[TYPE_LSB +: 2] != 2'h3) && (w[RANGE_LSB +: 2] != 2'h3) && (w[REACT_LSB +: 2] != 2'h3);
  endfunction

  function automatic aoc_type_e type_of(input logic [CH_W-1:0] w);
    type_of = aoc_type_e'(w[TYPE_LSB +: 2]);
  endfunction

  aoc_mem #(
    .W(VAL_W),
    .D(NCH),
    .AW(3)
  ) u_sub (
    .clock(clock),
    .resetn(resetn),
    .wr_en(mem_we),
    .wr_addr(ch_of(addr)),
    .wr_data(wdata[VAL_W-1:0]),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  // diagnostic conditions per channel, qualified by type, enables and output level
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [VAL_W-1:0] v;
    logic [CH_W-1:0] w;
    logic deact;
    logic big_sc;
    logic big_oc;
    logic c_sup;
    logic c_wire;
    logic c_short;
    logic c_over;
    logic c_under;
    assign v = cmd_value[c*VAL_W +: VAL_W];
    assign w = st_ff.act[c];
    assign deact = (type_of(w) == TYPE_OFF);
    assign big_sc = (v < NEG_SC) || (v > SC_TH);
    assign big_oc = (v < NEG_OC) || (v > OC_TH);
    assign c_sup = w[EN_LSB + D_SUP] && !supply_ok && !deact;
    assign c_wire = w[EN_LSB + D_WIRE] && (type_of(w) == TYPE_CURR) && big_oc && wire_det[c];
    assign c_short = w[EN_LSB + D_SHORT] && (type_of(w) == TYPE_VOLT) && big_sc && short_det[c];
    assign c_over = w[EN_LSB + D_OVER] && (v > OVR_LIM) && !deact;
    assign c_under = w[EN_LSB + D_UNDER] && (v < UND_LIM) && !deact;
    assign cond[c] = {c_under, c_over, c_short, c_wire, c_sup};
    assign out_type[2*c +: 2] = w[TYPE_LSB +: 2];
    assign out_range[2*c +: 2] = w[RANGE_LSB +: 2];

    chk_short_gate: assert property (evt[c][D_SHORT] |-> type_of(w) == TYPE_VOLT && (v < NEG_SC || v > SC_TH))
      else $error("short report outside voltage type or small output");
    chk_wire_gate: assert property (evt[c][D_WIRE] |-> type_of(w) == TYPE_CURR && (v < NEG_OC || v > OC_TH))
      else $error("open circuit report outside current type or small output");
    chk_deact_quiet: assert property (deact |-> cond[c] == '0)
      else $error("deactivated channel raised a diagnostic");
    chk_supply_each: assert property (c_sup && !st_ff.cond_q[c][D_SUP] |=> st_ff.sts0[S0_SUP + c])
      else $error("enabled channel missed its own supply report");
    chk_under_flag: assert property (evt[c][D_UNDER] |=> st_ff.sts1[S1_UNDER + c] ##1 1'b1)
      else $error("underflow event not latched");
  end

  // bus decode, commit sequencing, sticky status and the output scan
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_sub = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.scan_v = 1'b0;
    mem_ra = st_ff.scan;
    mem_we = 1'b0;
    err_evt = 1'b0;
    set0 = 32'h0000_0000;
    set1 = 9'h000;
    clr0 = 32'h0000_0000;
    clr1 = 9'h000;
    k = st_ff.scan_d;
    all_ok = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      all_ok = all_ok && word_ok(st_ff.stage[c]);
    end
    evt = cond & ~st_ff.cond_q;
    nxt_st.cond_q = cond;

    // a software read of a substitute word borrows the memory port; the scan waits one cycle
    if (rd_stb && in_blk(addr, OFS_SUB)) begin
      mem_ra = ch_of(addr);
      nxt_st.rd_sub = 1'b1;
    end else begin
      nxt_st.scan = st_ff.scan + 3'h1;
      nxt_st.scan_d = st_ff.scan;
      nxt_st.scan_v = 1'b1;
    end

    // read data registered for the following cycle; unmapped reads give zero
    if (rd_stb) begin
      if (addr == OFS_CTRL) begin
        nxt_st.rdata[CTRL_STOP] = st_ff.cpu_stop;
        nxt_st.rdata[CTRL_RUN] = st_ff.run;
        nxt_st.rdata[CTRL_BUSY] = (st_ff.cfg == CFG_CHECK);
      end else if (addr == OFS_RATE) begin
        nxt_st.rdata[4:0] = st_ff.rate;
      end else if (addr == OFS_STS0) begin
        nxt_st.rdata = st_ff.sts0;
      end else if (addr == OFS_MSK0) begin
        nxt_st.rdata = st_ff.msk0;
      end else if (addr == OFS_STS1) begin
        nxt_st.rdata[8:0] = st_ff.sts1;
      end else if (addr == OFS_MSK1) begin
        nxt_st.rdata[8:0] = st_ff.msk1;
      end else if (in_blk(addr, OFS_STAGE)) begin
        nxt_st.rdata[CH_W-1:0] = st_ff.stage[ch_of(addr)];
      end else if (in_blk(addr, OFS_ACT)) begin
        nxt_st.rdata[CH_W-1:0] = st_ff.act[ch_of(addr)];
      end
    end

    if (wr_stb) begin
      if (addr == OFS_CTRL) begin
        nxt_st.cpu_stop = wdata[CTRL_STOP];
        nxt_st.run = wdata[CTRL_RUN];
      end else if (addr == OFS_RATE) begin
        // rate is frozen while running, out-of-range values are dropped
        if (!st_ff.run && wdata[4:0] >= RATE_MIN && wdata[4:0] <= RATE_MAX && wdata[31:5] == '0) begin
          nxt_st.rate = wdata[4:0];
        end
      end else if (addr == OFS_STS0) begin
        clr0 = wdata;
      end else if (addr == OFS_MSK0) begin
        nxt_st.msk0 = wdata;
      end else if (addr == OFS_STS1) begin
        clr1 = wdata[8:0];
      end else if (addr == OFS_MSK1) begin
        nxt_st.msk1 = wdata[8:0];
      end else if (in_blk(addr, OFS_STAGE)) begin
        nxt_st.stage[ch_of(addr)] = wdata[CH_W-1:0];
      end else if (in_blk(addr, OFS_SUB)) begin
        mem_we = 1'b1;
      end
    end

    // staged words only reach the channels after the whole set checks out
    unique case (st_ff.cfg)
      CFG_IDLE: begin
        if (wr_stb && addr == OFS_CTRL && wdata[CTRL_COMMIT]) begin
          nxt_st.cfg = CFG_CHECK;
        end
      end
      CFG_CHECK: begin
        nxt_st.cfg = CFG_IDLE;
        if (all_ok) begin
          for (int c = 0; c < NCH; c++) begin
            if (st_ff.run) begin
              // diagnostic enables may not change while running
              nxt_st.act[c] = {st_ff.act[c][CH_W-1:EN_LSB], st_ff.stage[c][EN_LSB-1:0]};
            end else begin
              nxt_st.act[c] = st_ff.stage[c];
            end
          end
        end else begin
          err_evt = 1'b1;
        end
      end
    endcase

    // events set sticky bits; a set in the clearing cycle wins
    for (int c = 0; c < NCH; c++) begin
      set0[S0_SUP + c] = evt[c][D_SUP];
      set0[S0_WIRE + c] = evt[c][D_WIRE];
      set0[S0_SHORT + c] = evt[c][D_SHORT];
      set0[S0_OVER + c] = evt[c][D_OVER];
      set1[S1_UNDER + c] = evt[c][D_UNDER];
    end
    set1[S1_ERR] = err_evt;
    nxt_st.sts0 = (st_ff.sts0 & ~clr0) | set0;
    nxt_st.sts1 = (st_ff.sts1 & ~clr1) | set1;

    // one channel per scan step; substitute data arrive a cycle after the read
    if (st_ff.scan_v) begin
      if (type_of(st_ff.act[k]) == TYPE_OFF) begin
        nxt_st.drive_en[k] = 1'b0;
        nxt_st.drive[k] = '0;
      end else if (!st_ff.cpu_stop) begin
        nxt_st.drive_en[k] = 1'b1;
        nxt_st.drive[k] = cmd_value[k*VAL_W +: VAL_W];
      end else begin
        unique case (aoc_react_e'(st_ff.act[k][REACT_LSB +: 2]))
          REACT_OFF: begin
            nxt_st.drive_en[k] = 1'b0;
            nxt_st.drive[k] = '0;
          end
          REACT_HOLD: begin
            nxt_st.drive[k] = st_ff.drive[k];
          end
          REACT_SUBST: begin
            nxt_st.drive_en[k] = 1'b1;
            nxt_st.drive[k] = mem_rd;
          end
          default: begin
            nxt_st.drive_en[k] = 1'b0;
            nxt_st.drive[k] = '0;
          end
        endcase
      end
    end
  end

  // defaults: voltage, bipolar range, turn off on stop, diagnostics off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.rate <= RATE_RST;
      st_ff.stage <= {NCH{CFG_RST}};
      st_ff.act <= {NCH{CFG_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rd_sub ? {{(32-VAL_W){1'b0}}, mem_rd} : st_ff.rdata;
  assign drive_value = st_ff.drive;
  assign drive_en = st_ff.drive_en;
  assign output_rate = st_ff.rate;
  // level interrupt while any unmasked sticky bit stands
  assign irq = (|(st_ff.sts0 & st_ff.msk0)) || (|(st_ff.sts1 & st_ff.msk1));

  // helper: has any commit been evaluated since reset
  logic commit_seen;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      commit_seen <= 1'b0;
    end else if (st_ff.cfg == CFG_CHECK) begin
      commit_seen <= 1'b1;
    end
  end

  sequence s_commit;
    wr_stb && addr == OFS_CTRL && wdata[CTRL_COMMIT] && st_ff.cfg == CFG_IDLE;
  endsequence
  sequence s_check_bad;
    st_ff.cfg == CFG_CHECK && !all_ok;
  endsequence

  chk_reset_cfg: assert property (!commit_seen |-> st_ff.act == {NCH{CFG_RST}})
    else $error("channel left default configuration without a commit");
  chk_rate_lock: assert property (st_ff.run && wr_stb && addr == OFS_RATE |=> $stable(st_ff.rate))
    else $error("output rate changed while running");
  chk_rate_range: assert property (st_ff.rate >= RATE_MIN && st_ff.rate <= RATE_MAX)
    else $error("output rate outside one to sixteen");
  chk_act_commit: assert property ($changed(st_ff.act) |-> $past(st_ff.cfg) == CFG_CHECK)
    else $error("active configuration changed outside a commit");
  chk_commit_reject: assert property (s_commit ##1 s_check_bad |=> st_ff.sts1[S1_ERR] && $stable(st_ff.act))
    else $error("invalid parameter set was applied or not flagged");
  chk_enable_lock: assert property (st_ff.cfg == CFG_CHECK && st_ff.run |=>
      st_ff.act[0][CH_W-1:EN_LSB] == $past(st_ff.act[0][CH_W-1:EN_LSB]))
    else $error("diagnostic enable changed while running");
  chk_deact_off: assert property (st_ff.scan_v && type_of(st_ff.act[st_ff.scan_d]) == TYPE_OFF |=>
      !st_ff.drive_en[$past(st_ff.scan_d)])
    else $error("deactivated channel still driven");
  chk_stop_subst: assert property (st_ff.scan_v && st_ff.cpu_stop && type_of(st_ff.act[st_ff.scan_d]) != TYPE_OFF
      && st_ff.act[st_ff.scan_d][REACT_LSB +: 2] == REACT_SUBST |=>
      st_ff.drive_en[$past(st_ff.scan_d)] && st_ff.drive[$past(st_ff.scan_d)] == $past(mem_rd))
    else $error("substitute value not driven in stop");
  chk_stop_off: assert property (st_ff.scan_v && st_ff.cpu_stop
      && st_ff.act[st_ff.scan_d][REACT_LSB +: 2] == REACT_OFF |=> !st_ff.drive_en[$past(st_ff.scan_d)])
    else $error("turn-off reaction left channel driven");
  chk_run_follow: assert property (st_ff.scan_v && !st_ff.cpu_stop && type_of(st_ff.act[st_ff.scan_d]) != TYPE_OFF
      |=> st_ff.drive[$past(st_ff.scan_d)] == $past(cmd_value[st_ff.scan_d*VAL_W +: VAL_W]))
    else $error("running channel not following commanded value");
  chk_over_flag: assert property (|evt[0][D_OVER] |=> st_ff.sts0[S0_OVER])
    else $error("overflow event not latched");
endmodule
`default_nettype wire

// file: bench/aoc_cpu.sv
// controller model that writes and reads parameter words over the register port
`timescale 1ns/100ps
`default_nettype none
module aoc_cpu (
  input wire logic clock,
  input wire logic [31:0] rdata,
  output logic [aoc_pkg::ADDR_W-1:0] addr,
  output logic [31:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  // bus idles with strobes low from time zero
  initial begin
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one word per call; each channel word is its own transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    // released lines show the inverse so stale values cannot pass for held ones
    addr <= ~a;
    wdata <= ~d;
  endtask

  // read data is taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    addr <= ~a;
    @(negedge clock);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the channel configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import aoc_pkg::*;
  localparam logic [12:0] CFG [8] = '{13'h1D28, 13'h0215, 13'h1F02, 13'h0508,
                                     13'h0008, 13'h0008, 13'h0008, 13'h0008};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rdata;
  logic [127:0] cmd_value = '0;
  logic supply_ok = 1'b1;
  logic [7:0] wire_det = '0;
  logic [7:0] short_det = '0;
  logic [127:0] drive_value;
  logic [7:0] drive_en;
  logic [15:0] out_type;
  logic [15:0] out_range;
  logic [4:0] output_rate;
  logic irq;
  int errors = 0;
  int n_compared = 0;

  // 40 mhz
  always #12.5 clock = ~clock;

  aoc_top i_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .cmd_value(cmd_value), .supply_ok(supply_ok), .wire_det(wire_det),
    .short_det(short_det), .drive_value(drive_value), .drive_en(drive_en), .out_type(out_type),
    .out_range(out_range), .output_rate(output_rate), .irq(irq));
  aoc_cpu i_cpu (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_cpu.rd(a, d);
    chk(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // set one commanded value at a rising edge
  task automatic cmd(input int c, input logic [15:0] v);
    @(posedge clock);
    cmd_value[16*c +: 16] <= v;
  endtask

  function automatic logic [7:0] ofs(input logic [7:0] base, input int c);
    return base + 8'(4 * c);
  endfunction

  task automatic test_done;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic t_reset;
    chk({16'h0, out_type}, 32'h0);
    chk({16'h0, out_range}, 32'hAAAA);
    chk({27'h0, output_rate}, 32'h1);
    chk({24'h0, drive_en}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      rc(ofs(OFS_ACT, c), 32'h0008);
      rc(ofs(OFS_SUB, c), 32'h0);
    end
    rc(8'hF0, 32'h0);
    rc(OFS_MSK0, 32'h0);
  endtask

  // boundary values of the sub-cycle count
  task automatic t_rate;
    i_cpu.wr(OFS_RATE, 32'h10);
    rc(OFS_RATE, 32'h10);
    i_cpu.wr(OFS_RATE, 32'h11);
    rc(OFS_RATE, 32'h10);
    i_cpu.wr(OFS_RATE, 32'h0);
    @(negedge clock);
    chk({27'h0, output_rate}, 32'h10);
  endtask

  task automatic t_commit;
    for (int c = 0; c < 8; c++) i_cpu.wr(ofs(OFS_STAGE, c), {19'h0, CFG[c]});
    chk({16'h0, out_type}, 32'h0);
    i_cpu.wr(OFS_CTRL, 32'h4);
    cyc(3);
    chk({16'h0, out_type}, 32'h0024);
    chk({16'h0, out_range}, 32'hAA86);
    rc(ofs(OFS_ACT, 1), 32'h0215);
    // an illegal field code rejects the whole set
    i_cpu.wr(ofs(OFS_STAGE, 4), 32'h3);
    i_cpu.wr(OFS_CTRL, 32'h4);
    cyc(3);
    rc(OFS_STS1, 32'h100);
    rc(ofs(OFS_ACT, 4), 32'h0008);
    i_cpu.wr(ofs(OFS_STAGE, 4), 32'h0008);
    i_cpu.wr(OFS_STS1, 32'h100);
  endtask

  task automatic t_drive;
    cmd(0, 16'h0300);
    cmd(1, 16'h0500);
    cmd(2, 16'h7FFF);
    cmd(3, 16'h0100);
    cyc(12);
    chk({16'h0, drive_value[15:0]}, 32'h0300);
    chk({24'h0, drive_en}, 32'hFB);
    i_cpu.wr(ofs(OFS_SUB, 0), 32'h1234);
    i_cpu.wr(OFS_CTRL, 32'h1);
    cmd(1, 16'h0600);
    cyc(12);
    chk({16'h0, drive_value[15:0]}, 32'h1234);
    chk({16'h0, drive_value[31:16]}, 32'h0500);
    chk({16'h0, drive_value[63:48]}, 32'h0);
    chk({24'h0, drive_en}, 32'h03);
    i_cpu.wr(OFS_CTRL, 32'h0);
  endtask

  task automatic t_diag;
    @(posedge clock);
    short_det <= 8'hFF;
    wire_det <= 8'hFF;
    supply_ok <= 1'b0;
    cyc(3);
    rc(OFS_STS0, 32'h00010209);
    i_cpu.wr(OFS_MSK0, 32'h1);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    i_cpu.wr(OFS_STS0, 32'hFFFFFFFF);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    rc(OFS_STS0, 32'h0);
    cmd(0, 16'h7100);
    cyc(3);
    rc(OFS_STS0, 32'h01000000);
    cmd(0, 16'h8000);
    cyc(3);
    rc(OFS_STS1, 32'h1);
  endtask

  // running locks the rate and the diagnostic enables
  task automatic t_lock;
    i_cpu.wr(OFS_CTRL, 32'h2);
    i_cpu.wr(OFS_RATE, 32'h5);
    rc(OFS_RATE, 32'h10);
    i_cpu.wr(ofs(OFS_STAGE, 3), 32'h0008);
    i_cpu.wr(OFS_CTRL, 32'h6);
    cyc(3);
    rc(ofs(OFS_ACT, 3), 32'h0508);
  endtask

  // guards against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end

  initial begin
    cyc(2);
    resetn <= 1'b1;
    t_reset();
    t_rate();
    t_commit();
    t_drive();
    t_diag();
    t_lock();
    test_done();
  end
endmodule
`default_nettype wire
